// ===== rtl/oda_top.sv
// Function
// (R1) control bit 0 marks partial multi-message data
// (R2) control bit 1 selects one or two bytes
// (R3) control bit 2 adds a counter byte; object replies echo bit 2 but carry no counter byte
// (R4) master keeps reserved and unsupported bits zero
// (R5) control bit 7: zero read, one write
// (R6) error when read length exceeds object size
// (R7) function 66h reads a whole array object
// (R8) subfunction 55h restarts read-out at subindex 00h
// (R9) master continues with subfunction AAh
// (R10) error reply after the last entry
// (R11) array request: address, code, sub, 00h, index, crc
// (R12) response header, object frames, two-byte crc
// (R13) frame: index lo, index hi, sub, count, data
// (R14) unsupported option gives exception AEh with bitmap
// (R15) general error: ABh, FFh, length 6, 0Dh, CEh, code
// (R16) crc-16 appended low first, bad frames dropped
module oda_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm register slave
	input wire logic [4:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire logic [31:0] av_writedata,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	output logic irq,
	// received frame bytes from the uart layer
	input wire oda_pkg::oda_byte_t rx_data,
	input wire logic rx_valid,
	input wire logic rx_eof,
	// response bytes to the uart layer
	output oda_pkg::oda_byte_t tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// object dictionary lookup
	output logic od_req,
	output logic [15:0] od_index,
	output logic [7:0] od_subindex,
	input wire logic od_ack,
	input wire logic od_found,
	input wire logic [2:0] od_size,
	input wire logic [31:0] od_data
);
	import oda_pkg::*;

	function automatic oda_byte_t word_byte(input logic [31:0] w,
		input logic [1:0] k);
		word_byte = w[8*k +: 8];
	endfunction : word_byte

	oda_crc_if rx_cif ();
	oda_crc_if tx_cif ();
	oda_crc u_rx_crc (.sys_clk(sys_clk), .rst(rst), .cif(rx_cif.core));
	oda_crc u_tx_crc (.sys_clk(sys_clk), .rst(rst), .cif(tx_cif.core));

	oda_state_e state_reg, state_next;
	oda_kind_e kind_reg, kind_next;
	oda_byte_t rxbuf_reg [ODA_BUF_DEPTH];
	oda_byte_t rxbuf_next [ODA_BUF_DEPTH];
	oda_byte_t txbuf_reg [ODA_BUF_DEPTH];
	oda_byte_t txbuf_next [ODA_BUF_DEPTH];
	logic [4:0] rx_cnt_reg, rx_cnt_next;
	logic [15:0] idx_reg, idx_next;
	logic [7:0] sub_reg, sub_next;
	logic [7:0] rlen_reg, rlen_next;
	logic [15:0] pc_reg, pc_next;
	logic [7:0] sfc_reg, sfc_next;
	logic [31:0] err_reg, err_next;
	logic [31:0] data_reg, data_next;
	logic [2:0] size_reg, size_next;
	logic active_reg, active_next;
	logic [7:0] pos_reg, pos_next;
	logic is_array_reg, is_array_next;
	logic od_req_reg, od_req_next;
	logic [15:0] od_index_reg, od_index_next;
	logic [7:0] od_sub_reg, od_sub_next;
	logic [4:0] tx_len_reg, tx_len_next;
	logic [4:0] tx_ptr_reg, tx_ptr_next;
	oda_byte_t tx_data_reg, tx_data_next;
	logic tx_valid_reg, tx_valid_next;
	logic [7:0] crc_hi_reg, crc_hi_next;
	logic [3:0] ev;
	logic [4:0] pc_off;
	logic [4:0] ptr_inc;
	logic [4:0] last_len;
	logic [15:0] pc_rx;
	logic [4:0] base;
	// register slave: one wait cycle, then a single accept cycle
	logic [31:0] ctrl_reg, ctrl_next;
	logic [3:0] status_reg, status_next;
	logic [3:0] mask_reg, mask_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic take;

	// control field as received, offset of the field after it
	always_comb begin
		if (rxbuf_reg[3][ODA_PC_WIDE]) begin // (R2)
			pc_rx = {rxbuf_reg[4], rxbuf_reg[3]};
		end else begin
			pc_rx = {8'h00, rxbuf_reg[3]};
		end
		pc_off = 5'd4 + {4'd0, rxbuf_reg[3][ODA_PC_WIDE]} +
			{4'd0, rxbuf_reg[3][ODA_PC_COUNTER]}; // (R3)
		last_len = rx_cnt_reg - 5'd3;
		ptr_inc = tx_ptr_reg + 5'd1;
		base = pc_reg[ODA_PC_WIDE] ? 5'd5 : 5'd4;
	end

	assign rx_cif.clr = (state_reg == ODA_ST_PARSE);
	assign rx_cif.en = rx_valid && (state_reg == ODA_ST_IDLE) &&
		(rx_cnt_reg <= 5'd16);
	assign rx_cif.data = rx_data;
	assign tx_cif.clr = (state_reg == ODA_ST_BUILD);
	assign tx_cif.en = tx_valid_reg && tx_ready && (tx_ptr_reg < tx_len_reg);
	assign tx_cif.data = tx_data_reg;

	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		rxbuf_next = rxbuf_reg;
		txbuf_next = txbuf_reg;
		rx_cnt_next = rx_cnt_reg;
		idx_next = idx_reg;
		sub_next = sub_reg;
		rlen_next = rlen_reg;
		pc_next = pc_reg;
		sfc_next = sfc_reg;
		err_next = err_reg;
		data_next = data_reg;
		size_next = size_reg;
		active_next = active_reg;
		pos_next = pos_reg;
		is_array_next = is_array_reg;
		od_req_next = od_req_reg;
		od_index_next = od_index_reg;
		od_sub_next = od_sub_reg;
		tx_len_next = tx_len_reg;
		tx_ptr_next = tx_ptr_reg;
		tx_data_next = tx_data_reg;
		tx_valid_next = tx_valid_reg;
		crc_hi_next = crc_hi_reg;
		ev = 4'h0;
		case (state_reg)
			ODA_ST_IDLE: begin
				// bytes beyond the buffer only mark the frame as too long
				if (rx_cif.en) begin
					if (rx_cnt_reg < 5'd16) begin
						rxbuf_next[rx_cnt_reg[3:0]] = rx_data;
					end
					rx_cnt_next = rx_cnt_reg + 5'd1;
				end else if (rx_eof && rx_cnt_reg != 5'd0) begin
					state_next = ODA_ST_PARSE;
				end
			end
			ODA_ST_PARSE: begin
				rx_cnt_next = 5'd0;
				state_next = ODA_ST_IDLE;
				kind_next = ODA_RK_GEN;
				if (rx_cif.crc != 16'h0000) begin // (R16)
					ev[ODA_EV_CRC] = 1'b1;
				end else if (rx_cnt_reg >= ODA_MIN_FRAME &&
					rx_cnt_reg <= 5'd16 && ctrl_reg[ODA_CTRL_EN_BIT] &&
					rxbuf_reg[0] == ctrl_reg[ODA_CTRL_ADDR_LSB +: 8]) begin
					sfc_next = rxbuf_reg[2];
					if (rxbuf_reg[1] == ODA_FC_ARRAY) begin // (R7)
						is_array_next = 1'b1;
						// index travels high byte first
						idx_next = {rxbuf_reg[4], rxbuf_reg[5]}; // (R11)
						if (rxbuf_reg[2] == ODA_SF_START) begin
							pos_next = 8'h00; // (R8)
							active_next = 1'b1;
							state_next = ODA_ST_LOOK;
						end else if (rxbuf_reg[2] == ODA_SF_CONT &&
							active_reg) begin
							idx_next = idx_reg; // (R9)
							state_next = ODA_ST_LOOK;
						end else begin
							err_next = ODA_ERR_CMD;
							state_next = ODA_ST_BUILD;
						end
					end else if (rxbuf_reg[1] == ODA_FC_OBJ &&
						rxbuf_reg[2] == ODA_MEI) begin
						is_array_next = 1'b0;
						pc_next = pc_rx;
						state_next = ODA_ST_BUILD;
						if ((pc_rx & ~ODA_PC_SUPPORTED) != 16'h0000) begin
							kind_next = ODA_RK_OPT; // (R4) (R14)
						end else if (pc_rx[ODA_PC_ACCESS]) begin
							err_next = ODA_ERR_ACCESS; // (R5)
						end else if (pc_rx[ODA_PC_MULTI]) begin
							err_next = ODA_ERR_UNSUP; // (R1)
						end else begin
							idx_next = {rxbuf_reg[4'(pc_off + 5'd2)],
								rxbuf_reg[4'(pc_off + 5'd1)]};
							sub_next = rxbuf_reg[4'(pc_off + 5'd3)];
							rlen_next = rxbuf_reg[last_len[3:0]];
							state_next = ODA_ST_LOOK;
						end
					end
				end
			end
			ODA_ST_LOOK: begin
				od_req_next = 1'b1;
				od_index_next = idx_reg;
				od_sub_next = is_array_reg ? pos_reg : sub_reg;
				if (od_req_reg && od_ack) begin
					od_req_next = 1'b0;
					data_next = od_data;
					size_next = od_size;
					state_next = ODA_ST_BUILD;
					kind_next = ODA_RK_GEN;
					if (is_array_reg) begin
						if (!od_found) begin
							err_next = ODA_ERR_GENERAL; // (R10)
							active_next = 1'b0;
							ev[ODA_EV_END] = 1'b1;
						end else begin
							kind_next = ODA_RK_ARRAY;
							pos_next = pos_reg + 8'h01;
						end
					end else if (!od_found) begin
						err_next = ODA_ERR_ACCESS;
					end else if (rlen_reg > {5'd0, od_size}) begin
						err_next = ODA_ERR_TOO_LONG; // (R6)
					end else begin
						kind_next = ODA_RK_OBJ;
					end
				end
			end
			ODA_ST_BUILD: begin
				for (int i = 0; i < ODA_BUF_DEPTH; i++) begin
					txbuf_next[i] = 8'h00;
				end
				txbuf_next[0] = ctrl_reg[ODA_CTRL_ADDR_LSB +: 8];
				case (kind_reg)
					ODA_RK_ARRAY: begin
						txbuf_next[1] = ODA_FC_ARRAY; // (R12)
						txbuf_next[2] = sfc_reg;
						txbuf_next[3] = 8'd4 + {5'd0, size_reg};
						txbuf_next[4] = idx_reg[7:0]; // (R13)
						txbuf_next[5] = idx_reg[15:8];
						txbuf_next[6] = od_sub_reg;
						txbuf_next[7] = {5'd0, size_reg};
						for (int k = 0; k < 4; k++) begin
							txbuf_next[8 + k] = word_byte(data_reg, 2'(k));
						end
						tx_len_next = 5'd8 + {2'd0, size_reg};
					end
					ODA_RK_OBJ: begin
						txbuf_next[1] = ODA_FC_OBJ;
						txbuf_next[2] = ODA_MEI;
						txbuf_next[3] = pc_reg[7:0];
						txbuf_next[4] = pc_reg[15:8];
						txbuf_next[4'(base)] = idx_reg[7:0];
						txbuf_next[4'(base + 5'd1)] = idx_reg[15:8];
						txbuf_next[4'(base + 5'd2)] = sub_reg;
						txbuf_next[4'(base + 5'd3)] = {5'd0, size_reg};
						for (int k = 0; k < 4; k++) begin
							txbuf_next[4'(base + 5'd4 + 5'(k))] =
								word_byte(data_reg, 2'(k));
						end
						tx_len_next = base + 5'd4 + {2'd0, size_reg};
					end
					ODA_RK_OPT: begin
						txbuf_next[1] = ODA_FC_ERR; // (R14)
						txbuf_next[2] = ODA_EXT_EXC;
						txbuf_next[4] = ODA_OPT_LEN_BASE + 8'd1 +
							{7'd0, pc_reg[ODA_PC_WIDE]};
						txbuf_next[5] = ODA_MEI;
						txbuf_next[6] = ODA_EXC_OPT;
						txbuf_next[7] = ODA_PC_SUPPORTED[7:0];
						txbuf_next[8] = ODA_PC_SUPPORTED[15:8];
						tx_len_next = 5'd8 + {4'd0, pc_reg[ODA_PC_WIDE]};
						ev[ODA_EV_ERR] = 1'b1;
					end
					default: begin
						txbuf_next[1] = ODA_FC_ERR; // (R15)
						txbuf_next[2] = ODA_EXT_EXC;
						txbuf_next[4] = ODA_GEN_LEN;
						txbuf_next[5] = ODA_MEI;
						txbuf_next[6] = ODA_EXC_GEN;
						for (int k = 0; k < 4; k++) begin
							txbuf_next[7 + k] = word_byte(err_reg, 2'(k));
						end
						tx_len_next = 5'd11;
						ev[ODA_EV_ERR] = 1'b1;
					end
				endcase
				tx_ptr_next = 5'd0;
				tx_data_next = txbuf_next[0];
				tx_valid_next = 1'b1;
				state_next = ODA_ST_SEND;
			end
			ODA_ST_SEND: begin
				// crc bytes follow the body, low byte first
				if (tx_valid_reg && tx_ready) begin
					tx_ptr_next = ptr_inc;
					if (ptr_inc < tx_len_reg) begin
						tx_data_next = txbuf_reg[ptr_inc[3:0]];
					end else if (ptr_inc == tx_len_reg) begin
						tx_data_next = tx_cif.crc_next[7:0]; // (R16)
						crc_hi_next = tx_cif.crc_next[15:8];
					end else if (ptr_inc == tx_len_reg + 5'd1) begin
						tx_data_next = crc_hi_reg;
					end else begin
						tx_valid_next = 1'b0;
						ev[ODA_EV_SENT] = 1'b1;
						state_next = ODA_ST_IDLE;
					end
				end
			end
			default: begin
				state_next = ODA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ODA_ST_IDLE;
			kind_reg <= ODA_RK_GEN;
			for (int i = 0; i < ODA_BUF_DEPTH; i++) begin
				rxbuf_reg[i] <= 8'h00;
				txbuf_reg[i] <= 8'h00;
			end
			rx_cnt_reg <= 5'd0;
			idx_reg <= 16'h0000;
			sub_reg <= 8'h00;
			rlen_reg <= 8'h00;
			pc_reg <= 16'h0000;
			sfc_reg <= 8'h00;
			err_reg <= 32'h0000_0000;
			data_reg <= 32'h0000_0000;
			size_reg <= 3'd0;
			active_reg <= 1'b0;
			pos_reg <= 8'h00;
			is_array_reg <= 1'b0;
			od_req_reg <= 1'b0;
			od_index_reg <= 16'h0000;
			od_sub_reg <= 8'h00;
			tx_len_reg <= 5'd0;
			tx_ptr_reg <= 5'd0;
			tx_data_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
			crc_hi_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			rxbuf_reg <= rxbuf_next;
			txbuf_reg <= txbuf_next;
			rx_cnt_reg <= rx_cnt_next;
			idx_reg <= idx_next;
			sub_reg <= sub_next;
			rlen_reg <= rlen_next;
			pc_reg <= pc_next;
			sfc_reg <= sfc_next;
			err_reg <= err_next;
			data_reg <= data_next;
			size_reg <= size_next;
			active_reg <= active_next;
			pos_reg <= pos_next;
			is_array_reg <= is_array_next;
			od_req_reg <= od_req_next;
			od_index_reg <= od_index_next;
			od_sub_reg <= od_sub_next;
			tx_len_reg <= tx_len_next;
			tx_ptr_reg <= tx_ptr_next;
			tx_data_reg <= tx_data_next;
			tx_valid_reg <= tx_valid_next;
			crc_hi_reg <= crc_hi_next;
		end
	end

	always_comb begin
		take = (av_read || av_write) && !wait_reg;
		wait_next = !((av_read || av_write) && wait_reg);
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		rdata_next = rdata_reg;
		status_next = status_reg;
		if ((av_read || av_write) && wait_reg) begin
			case (av_address)
				ODA_OFS_CTRL: rdata_next = ctrl_reg;
				ODA_OFS_STATUS: rdata_next = {28'h0, status_reg};
				ODA_OFS_MASK: rdata_next = {28'h0, mask_reg};
				ODA_OFS_POS: rdata_next = {23'h0, active_reg, pos_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		// clear only what was read; an event in the wait cycle survives
		if (take && av_read && av_address == ODA_OFS_STATUS) begin
			status_next = status_reg & ~rdata_reg[3:0];
		end
		// a new event wins over the read that clears it
		status_next = status_next | ev;
		if (take && av_write) begin
			case (av_address)
				ODA_OFS_CTRL: ctrl_next = {16'h0, av_writedata[15:8],
					7'h0, av_writedata[0]};
				ODA_OFS_MASK: mask_next = av_writedata[3:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= ODA_CTRL_RST;
			status_reg <= ODA_STATUS_RST;
			mask_reg <= ODA_MASK_RST;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end

	assign av_readdata = rdata_reg;
	assign av_waitrequest = wait_reg;
	assign irq = irq_reg;
	assign tx_data = tx_data_reg;
	assign tx_valid = tx_valid_reg;
	assign od_req = od_req_reg;
	assign od_index = od_index_reg;
	assign od_subindex = od_sub_reg;
endmodule : oda_top

// ===== pkg/oda_pkg.sv
package oda_pkg;
	// register map, byte addresses on the avalon slave
	localparam logic [4:0] ODA_OFS_CTRL = 5'h00;
	localparam logic [4:0] ODA_OFS_STATUS = 5'h04;
	localparam logic [4:0] ODA_OFS_MASK = 5'h08;
	localparam logic [4:0] ODA_OFS_POS = 5'h0C;
	localparam int ODA_CTRL_EN_BIT = 0;
	localparam int ODA_CTRL_ADDR_LSB = 8;
	localparam logic [31:0] ODA_CTRL_RST = 32'h0000_0001;
	localparam logic [3:0] ODA_STATUS_RST = 4'h0;
	localparam logic [3:0] ODA_MASK_RST = 4'h0;
	// status event bits
	localparam int ODA_EV_SENT = 0;
	localparam int ODA_EV_CRC = 1;
	localparam int ODA_EV_ERR = 2;
	localparam int ODA_EV_END = 3;
	// protocol control field bits
	localparam int ODA_PC_MULTI = 0;
	localparam int ODA_PC_WIDE = 1;
	localparam int ODA_PC_COUNTER = 2;
	localparam int ODA_PC_ACCESS = 7;
	localparam logic [15:0] ODA_PC_SUPPORTED = 16'h0087;
	// frame codes
	localparam logic [7:0] ODA_FC_OBJ = 8'h2B;
	localparam logic [7:0] ODA_FC_ARRAY = 8'h66;
	localparam logic [7:0] ODA_FC_ERR = 8'hAB;
	localparam logic [7:0] ODA_MEI = 8'h0D;
	localparam logic [7:0] ODA_SF_START = 8'h55;
	localparam logic [7:0] ODA_SF_CONT = 8'hAA;
	localparam logic [7:0] ODA_EXT_EXC = 8'hFF;
	localparam logic [7:0] ODA_EXC_GEN = 8'hCE;
	localparam logic [7:0] ODA_EXC_OPT = 8'hAE;
	localparam logic [7:0] ODA_GEN_LEN = 8'h06;
	localparam logic [7:0] ODA_OPT_LEN_BASE = 8'h02;
	// error codes carried by the general error reply
	localparam logic [31:0] ODA_ERR_UNSUP = 32'hFFFF_1003;
	localparam logic [31:0] ODA_ERR_CMD = 32'hFFFF_0003;
	localparam logic [31:0] ODA_ERR_ACCESS = 32'hFFFF_0008;
	localparam logic [31:0] ODA_ERR_TOO_LONG = 32'hFFFF_0012;
	localparam logic [31:0] ODA_ERR_GENERAL = 32'hFFFF_0019;
	// crc-16 of modbus rtu, reflected
	localparam logic [15:0] ODA_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] ODA_CRC_POLY = 16'hA001;
	localparam int ODA_BUF_DEPTH = 16;
	localparam logic [4:0] ODA_MIN_FRAME = 5'h06;
	typedef logic [7:0] oda_byte_t;
	typedef enum logic [4:0] {
		ODA_ST_IDLE = 5'h01,
		ODA_ST_PARSE = 5'h02,
		ODA_ST_LOOK = 5'h04,
		ODA_ST_BUILD = 5'h08,
		ODA_ST_SEND = 5'h10
	} oda_state_e;
	typedef enum logic [3:0] {
		ODA_RK_ARRAY = 4'h1,
		ODA_RK_OBJ = 4'h2,
		ODA_RK_GEN = 4'h4,
		ODA_RK_OPT = 4'h8
	} oda_kind_e;
endpackage : oda_pkg

// ===== pkg/oda_crc_if.sv
interface oda_crc_if;
	logic clr;
	logic en;
	logic [7:0] data;
	logic [15:0] crc;
	logic [15:0] crc_next;
	modport user (output clr, output en, output data, input crc,
		input crc_next);
	modport core (input clr, input en, input data, output crc,
		output crc_next);
endinterface : oda_crc_if

// ===== rtl/oda_crc.sv
module oda_crc (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// byte stream to fold in
	oda_crc_if.core cif
);
	import oda_pkg::*;
	logic [15:0] crc_reg;
	logic [15:0] crc_calc;
	logic [15:0] crc_next;

	always_comb begin
		crc_calc = crc_reg ^ {8'h00, cif.data};
		for (int i = 0; i < 8; i++) begin
			crc_calc = crc_calc[0] ? ((crc_calc >> 1) ^ ODA_CRC_POLY) :
				(crc_calc >> 1);
		end
		if (cif.clr) begin
			crc_next = ODA_CRC_INIT;
		end else if (cif.en) begin
			crc_next = crc_calc;
		end else begin
			crc_next = crc_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			crc_reg <= ODA_CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	assign cif.crc = crc_reg;
	assign cif.crc_next = crc_calc;
endmodule : oda_crc

// ===== sim/oda_top_chk.sv
module oda_top_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire logic av_read,
	input wire logic av_write,
	input wire logic av_waitrequest,
	// frame bytes
	input wire oda_pkg::oda_byte_t rx_data,
	input wire logic rx_valid,
	input wire logic rx_eof,
	input wire oda_pkg::oda_byte_t tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	// dictionary lookup
	input wire logic od_req,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_subindex,
	input wire logic od_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	import oda_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic [3:0] rxn_reg;
	logic [3:0] txn_reg;
	oda_byte_t rb_reg [0:7];
	oda_byte_t fc_reg;
	logic [15:0] crc_reg;
	function automatic logic [15:0] fold(logic [15:0] c, oda_byte_t d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ ODA_CRC_POLY : c >> 1;
		return c;
	endfunction : fold
	// a good frame folds its own crc to zero, so no end marker is needed
	always_ff @(posedge sys_clk) begin
		if (rst || rx_eof)
			rxn_reg <= 4'h0;
		else if (rx_valid && !rxn_reg[3]) begin
			rb_reg[rxn_reg[2:0]] <= rx_data;
			rxn_reg <= rxn_reg + 4'h1;
		end
		if (!tx_valid) begin
			txn_reg <= 4'h0;
			crc_reg <= ODA_CRC_INIT;
		end else if (tx_ready) begin
			txn_reg <= txn_reg + {3'h0, txn_reg != 4'hF};
			crc_reg <= fold(crc_reg, tx_data);
			if (txn_reg == 4'h1)
				fc_reg <= tx_data;
		end
	end
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("response byte moved");
	AST_OD_HOLD: assert property (od_req && !od_ack |=> od_req &&
		$stable({od_index, od_subindex})) else $error("lookup moved");
	AST_START_SUB0: assert property (rx_eof && rb_reg[1] == ODA_FC_ARRAY
		&& rb_reg[2] == ODA_SF_START |-> ##[1:8] (od_req &&
		od_subindex == 8'h00 && od_index == {rb_reg[4], rb_reg[5]}))
		else $error("start did not look up subindex zero");
	AST_ADDR_FIRST: assert property ($rose(tx_valid) |->
		tx_data == rb_reg[0]) else $error("reply address wrong");
	AST_CRC_RESIDUE: assert property ($fell(tx_valid) |->
		crc_reg == 16'h0000) else $error("reply crc wrong");
	AST_ERR_EXT: assert property (tx_valid && txn_reg == 4'h2 &&
		fc_reg == ODA_FC_ERR |-> tx_data == ODA_EXT_EXC)
		else $error("error reply exception byte wrong");
	AST_ERR_MEI: assert property (tx_valid && txn_reg == 4'h5 &&
		fc_reg == ODA_FC_ERR |-> tx_data == ODA_MEI)
		else $error("error reply type byte wrong");
	AST_ACK_TO_TX: assert property (od_ack |-> ##[1:4] tx_valid)
		else $error("no reply after lookup");
	AST_ONE_WAIT: assert property ((av_read || av_write) && av_waitrequest
		|=> !av_waitrequest ##1 av_waitrequest) else $error("bus wait");
	cov_gen: cover property (tx_valid && txn_reg == 4'h6 &&
		tx_data == ODA_EXC_GEN);
	cov_opt: cover property (tx_valid && txn_reg == 4'h6 &&
		tx_data == ODA_EXC_OPT);
	cov_arr: cover property (tx_valid && txn_reg == 4'h1 &&
		tx_data == ODA_FC_ARRAY);
endmodule : oda_top_chk

bind oda_top oda_top_chk oda_top_chk_i (.sys_clk, .rst, .av_read, .av_write,
	.av_waitrequest, .rx_data, .rx_valid, .rx_eof, .tx_data, .tx_valid,
	.tx_ready, .od_req, .od_index, .od_subindex, .od_ack);

// ===== sim/oda_mbm.sv
module oda_mbm (
	// clock
	input wire logic sys_clk,
	// request bytes to the slave
	output oda_pkg::oda_byte_t rx_data,
	output logic rx_valid,
	output logic rx_eof,
	// reply bytes from the slave
	input wire oda_pkg::oda_byte_t tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import oda_pkg::*;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_eof = 1'b0;
		tx_ready = 1'b0;
	end
	function automatic void add_crc(ref oda_byte_t q[$]);
		logic [15:0] c;
		c = ODA_CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ ODA_CRC_POLY : c >> 1;
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endfunction : add_crc
	// idle data line shows the inverse, never a stale copy of the byte
	task automatic send(input oda_byte_t q[$], input logic bad);
		add_crc(q);
		if (bad)
			q[q.size() - 1] = ~q[q.size() - 1];
		foreach (q[i]) begin
			@(posedge sys_clk);
			rx_data <= q[i];
			rx_valid <= 1'b1;
			@(posedge sys_clk);
			rx_valid <= 1'b0;
			rx_data <= ~q[i];
		end
		@(posedge sys_clk);
		rx_eof <= 1'b1;
		@(posedge sys_clk);
		rx_eof <= 1'b0;
	endtask : send
	// sink stalls every other cycle to exercise the hold of tx_data
	task automatic recv(output oda_byte_t q[$]);
		int idle;
		q = {};
		idle = 0;
		for (int n = 0; n < 300 && idle < 4; n++) begin
			@(posedge sys_clk);
			if (tx_valid && tx_ready)
				q.push_back(tx_data);
			idle = (q.size() > 0 && !tx_valid) ? idle + 1 : 0;
			tx_ready <= ~tx_ready;
		end
		tx_ready <= 1'b0;
	endtask : recv
endmodule : oda_mbm

// ===== sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import oda_pkg::*;
	typedef oda_byte_t oda_bytes_t[$];
	logic sys_clk, rst, av_read, av_write, av_waitrequest, irq;
	logic [4:0] av_address;
	logic [31:0] av_writedata, av_readdata, od_data;
	oda_byte_t rx_data, tx_data;
	logic rx_valid, rx_eof, tx_valid, tx_ready;
	logic od_req, od_ack, od_found;
	logic [15:0] od_index, last_idx;
	logic [7:0] od_subindex, last_sub, od_n;
	logic [2:0] od_size;
	logic [2:0] od_sz [0:3];
	logic [31:0] od_dt [0:3];
	int miscompares, samples_checked;
	oda_top oda_top_i (.sys_clk, .rst, .av_address, .av_read, .av_write,
		.av_writedata, .av_readdata, .av_waitrequest, .irq, .rx_data,
		.rx_valid, .rx_eof, .tx_data, .tx_valid, .tx_ready, .od_req,
		.od_index, .od_subindex, .od_ack, .od_found, .od_size, .od_data);
	oda_mbm oda_mbm_i (.sys_clk, .rx_data, .rx_valid, .rx_eof, .tx_data,
		.tx_valid, .tx_ready);
	always #5 sys_clk = ~sys_clk;
	// dictionary: entries below od_n exist, data invalid outside the answer
	always @(posedge sys_clk) begin
		od_ack <= 1'b0;
		od_data <= ~od_data;
		if (od_req && !od_ack) begin
			od_ack <= 1'b1;
			od_found <= od_subindex < od_n;
			od_size <= od_sz[od_subindex[1:0]];
			od_data <= od_dt[od_subindex[1:0]];
			last_sub <= od_subindex;
			last_idx <= od_index;
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, s, e);
		end
	endtask : chk
	task automatic av(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge sys_clk);
		av_address <= a;
		av_write <= wr;
		av_read <= !wr;
		av_writedata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (!av_waitrequest)
				break;
		end
		r = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
		if (n == 20) begin
			chk(32'h0, 32'h1, "bus hang");
			results();
		end
	endtask : av
	task automatic xact(input oda_bytes_t q, input oda_bytes_t e);
		oda_bytes_t g;
		oda_mbm_i.send(q, 1'b0);
		oda_mbm_i.recv(g);
		oda_mbm_i.add_crc(e);
		if (g.size() == 0) begin
			chk(32'h0, 32'h1, "no reply");
			results();
		end
		chk(g.size(), e.size(), "reply length");
		foreach (e[i])
			chk(g[i], e[i], "reply byte");
	endtask : xact
	function automatic oda_bytes_t gen(logic [31:0] c);
		return {8'h05, ODA_FC_ERR, ODA_EXT_EXC, 8'h00, ODA_GEN_LEN, ODA_MEI,
			ODA_EXC_GEN, c[7:0], c[15:8], c[23:16], c[31:24]};
	endfunction : gen
	function automatic oda_bytes_t opt(int w);
		oda_bytes_t q;
		q = {8'h05, ODA_FC_ERR, ODA_EXT_EXC, 8'h00, ODA_OPT_LEN_BASE + 8'(w),
			ODA_MEI, ODA_EXC_OPT, ODA_PC_SUPPORTED[7:0]};
		if (w == 2)
			q.push_back(ODA_PC_SUPPORTED[15:8]);
		return q;
	endfunction : opt
	function automatic oda_bytes_t rq(oda_bytes_t c, oda_byte_t n);
		return {8'h05, ODA_FC_OBJ, ODA_MEI, c, 8'h00, 8'h61, 8'h60, 8'h00,
			8'h00, 8'h00, 8'h00, n};
	endfunction : rq
	function automatic oda_bytes_t ok(oda_bytes_t c);
		return {8'h05, ODA_FC_OBJ, ODA_MEI, c, 8'h61, 8'h60, 8'h00, 8'h01,
			8'h42};
	endfunction : ok
	task automatic t_regs();
		logic [31:0] r;
		av(1'b0, ODA_OFS_CTRL, 32'h0, r);
		chk(r, ODA_CTRL_RST, "ctrl reset");
		av(1'b0, ODA_OFS_STATUS, 32'h0, r);
		chk(r, {28'h0, ODA_STATUS_RST}, "status reset");
		av(1'b0, 5'h1C, 32'h0, r);
		chk(r, 32'h0, "unmapped read");
		av(1'b1, ODA_OFS_CTRL, 32'h0000_0501, r);
		av(1'b1, ODA_OFS_MASK, 32'h0000_000F, r);
		av(1'b0, ODA_OFS_MASK, 32'h0, r);
		chk(r, 32'h0000_000F, "mask");
		$display("test regs done");
	endtask : t_regs
	task automatic t_array();
		oda_bytes_t a, e0;
		logic [31:0] r;
		od_n = 8'h02;
		od_sz = '{3'h2, 3'h1, 3'h1, 3'h1};
		od_dt = '{32'h7, 32'h5, 32'h0, 32'h0};
		a = {8'h05, ODA_FC_ARRAY, ODA_SF_CONT, 8'h00, 8'h24, 8'h00};
		xact(a, gen(ODA_ERR_CMD));
		a[2] = ODA_SF_START;
		e0 = {8'h05, ODA_FC_ARRAY, ODA_SF_START, 8'h06, 8'h00, 8'h24, 8'h00,
			8'h02, 8'h07, 8'h00};
		xact(a, e0);
		chk(last_idx, 16'h2400, "array index");
		av(1'b0, ODA_OFS_POS, 32'h0, r);
		chk(r, 32'h0000_0101, "read-out position");
		a[2] = ODA_SF_CONT;
		xact(a, {8'h05, ODA_FC_ARRAY, ODA_SF_CONT, 8'h05, 8'h00, 8'h24,
			8'h01, 8'h01, 8'h05});
		xact(a, gen(ODA_ERR_GENERAL));
		chk(irq, 1'b1, "irq raised");
		av(1'b1, ODA_OFS_MASK, 32'h0, r);
		repeat (3) @(posedge sys_clk);
		chk(irq, 1'b0, "irq masked");
		av(1'b1, ODA_OFS_MASK, 32'h0000_000F, r);
		av(1'b0, ODA_OFS_STATUS, 32'h0, r);
		chk(r[3:0], 4'hD, "sent, error and end events");
		repeat (3) @(posedge sys_clk);
		chk(irq, 1'b0, "irq cleared");
		a[2] = ODA_SF_START;
		xact(a, e0);
		chk(last_sub, 8'h00, "restart position");
		$display("test array done");
	endtask : t_array
	task automatic t_obj();
		oda_bytes_t g;
		logic [31:0] r;
		od_n = 8'h01;
		od_sz[0] = 3'h1;
		od_dt[0] = 32'h42;
		for (int b = 3; b < 7; b++)
			xact(rq({8'h01 << b}, 8'h01), opt(1));
		xact(rq({8'h02, 8'h01}, 8'h01), opt(2));
		xact(rq({8'h01}, 8'h01), gen(ODA_ERR_UNSUP));
		xact(rq({8'h80}, 8'h01), gen(ODA_ERR_ACCESS));
		xact(rq({8'h00}, 8'h02), gen(ODA_ERR_TOO_LONG));
		xact(rq({8'h00}, 8'h01), ok({8'h00}));
		xact(rq({8'h02, 8'h00}, 8'h01), ok({8'h02, 8'h00}));
		xact(rq({8'h04, 8'h07}, 8'h01), ok({8'h04}));
		oda_mbm_i.send(rq({8'h00}, 8'h01), 1'b1);
		oda_mbm_i.recv(g);
		chk(g.size(), 32'h0, "reply to corrupted frame");
		av(1'b0, ODA_OFS_STATUS, 32'h0, r);
		chk(r[ODA_EV_CRC], 1'b1, "crc event");
		$display("test object done");
	endtask : t_obj
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		av_address = 5'h00;
		av_read = 1'b0;
		av_write = 1'b0;
		av_writedata = 32'h0;
		od_n = 8'h00;
		miscompares = 0;
		samples_checked = 0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_array();
		t_obj();
		results();
	end
endmodule : tb_top
